// ---- pkg/lbpd_params.svh ----
// Constants for the LCD bias pin driver control block.
`ifndef LBPD_PARAMS_SVH
`define LBPD_PARAMS_SVH
`define LBPD_AW            12
`define LBPD_DW            32
`define LBPD_OFS_MAIN      12'h000
`define LBPD_OFS_SEG_LOW   12'h004
`define LBPD_OFS_SEG_MID   12'h008
`define LBPD_OFS_SEG_HIGH  12'h00C
`define LBPD_RST_MAIN      8'h00
`define LBPD_RST_SEG       8'h00
`define LBPD_BIT_PHASE     7
`define LBPD_BIT_CUR_HI    6
`define LBPD_BIT_CUR_LO    5
`define LBPD_BIT_MASTER    4
`define LBPD_SEG_HIGH_MASK 8'h0F
`define LBPD_NCOM          4
`define LBPD_NSEG          20
`endif

// ---- pkg/lbpd_pkg.sv ----
// Types shared by the LCD bias pin driver control block.
package lbpd_pkg;
  typedef enum logic [1:0] {LBPD_LV_VSS, LBPD_LV_THIRD, LBPD_LV_TWO_THIRD, LBPD_LV_VDD} lbpd_level_t;
  typedef struct packed {
    logic        lcd_mode;
    lbpd_level_t level;
  } lbpd_pin_t;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } lbpd_apb_req_t;
endpackage : lbpd_pkg

// ---- rtl/lbpd_top.sv ----
// LCD bias pin driver control with an APB register slave.
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/100ps
`include "lbpd_params.svh"
module lbpd_top (
  input  wire logic                 REF_CLK,
  input  wire logic                 NRST,
  input  wire lbpd_pkg::lbpd_apb_req_t APB_REQ,
  output logic                      PREADY,
  output logic [31:0]               PRDATA,
  output logic                      PSLVERR,
  input  wire logic [7:0]           PORT_A_DATA,
  input  wire logic [19:0]          SEG_DATA,
  output lbpd_pkg::lbpd_pin_t [3:0]  COM_PIN,
  output lbpd_pkg::lbpd_pin_t [19:0] SEG_PIN,
  output logic [1:0]                DRIVE_CURRENT
);
  import lbpd_pkg::*;

  // ==========================================================
  // Level selection.
  // A data bit of one picks the full rail of the phase, zero picks the bias level of the phase.
  // Commons and segments swing opposite ways, so one data value gives opposite rails on each.
  function automatic lbpd_level_t pick_level(input logic is_com,
                                             input logic phase,
                                             input logic data);
    lbpd_level_t lv;
    lv = LBPD_LV_VSS;
    if (is_com) begin
      if (!phase) begin
        lv = data ? LBPD_LV_VDD : LBPD_LV_THIRD;
      end else begin
        lv = data ? LBPD_LV_VSS : LBPD_LV_TWO_THIRD;
      end
    end else begin
      if (!phase) begin
        lv = data ? LBPD_LV_VSS : LBPD_LV_TWO_THIRD;
      end else begin
        lv = data ? LBPD_LV_VDD : LBPD_LV_THIRD;
      end
    end
    return lv;
  endfunction : pick_level

  // ==========================================================
  // Register file.
  // The high segment register keeps only its four implemented bits, so the rest read as zero.
  logic [7:0] lcd_main_control;
  logic [7:0] segment_enable_low;
  logic [7:0] segment_enable_mid;
  logic [7:0] segment_enable_high;
  logic [7:0] next_lcd_main_control;
  logic [7:0] next_segment_enable_low;
  logic [7:0] next_segment_enable_mid;
  logic [7:0] next_segment_enable_high;
  logic       wr_done;
  logic       addr_ok;

  assign addr_ok = (APB_REQ.paddr == `LBPD_OFS_MAIN) ||
                   (APB_REQ.paddr == `LBPD_OFS_SEG_LOW) ||
                   (APB_REQ.paddr == `LBPD_OFS_SEG_MID) ||
                   (APB_REQ.paddr == `LBPD_OFS_SEG_HIGH);
  assign wr_done = APB_REQ.psel && APB_REQ.penable && PREADY && APB_REQ.pwrite;

  always_comb begin
    next_lcd_main_control    = lcd_main_control;
    next_segment_enable_low  = segment_enable_low;
    next_segment_enable_mid  = segment_enable_mid;
    next_segment_enable_high = segment_enable_high;
    if (wr_done) begin
      unique case (APB_REQ.paddr)
        `LBPD_OFS_MAIN: begin
          next_lcd_main_control = APB_REQ.pwdata[7:0];
        end
        `LBPD_OFS_SEG_LOW: begin
          next_segment_enable_low = APB_REQ.pwdata[7:0];
        end
        `LBPD_OFS_SEG_MID: begin
          next_segment_enable_mid = APB_REQ.pwdata[7:0];
        end
        `LBPD_OFS_SEG_HIGH: begin
          next_segment_enable_high = APB_REQ.pwdata[7:0] & `LBPD_SEG_HIGH_MASK;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      lcd_main_control    <= `LBPD_RST_MAIN;
      segment_enable_low  <= `LBPD_RST_SEG;
      segment_enable_mid  <= `LBPD_RST_SEG;
      segment_enable_high <= `LBPD_RST_SEG;
    end else begin
      lcd_main_control    <= next_lcd_main_control;
      segment_enable_low  <= next_segment_enable_low;
      segment_enable_mid  <= next_segment_enable_mid;
      segment_enable_high <= next_segment_enable_high;
    end
  end

  // ==========================================================
  // APB response, no wait states.
  // Answering straight from the setup cycle keeps every transfer at two cycles.
  // Unmapped addresses answer with an error and leave every register untouched.
  logic        next_pready;
  logic [31:0] next_prdata;
  logic        next_pslverr;

  always_comb begin
    next_pready  = 1'b0;
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (APB_REQ.psel && !APB_REQ.penable) begin
      next_pready  = 1'b1;
      next_pslverr = !addr_ok;
      if (!APB_REQ.pwrite) begin
        unique case (APB_REQ.paddr)
          `LBPD_OFS_MAIN: begin
            next_prdata = {24'h000000, lcd_main_control};
          end
          `LBPD_OFS_SEG_LOW: begin
            next_prdata = {24'h000000, segment_enable_low};
          end
          `LBPD_OFS_SEG_MID: begin
            next_prdata = {24'h000000, segment_enable_mid};
          end
          `LBPD_OFS_SEG_HIGH: begin
            next_prdata = {24'h000000, segment_enable_high & `LBPD_SEG_HIGH_MASK};
          end
          default: begin
            next_prdata = 32'h0000_0000;
          end
        endcase
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= next_pready;
      PRDATA  <= next_prdata;
      PSLVERR <= next_pslverr;
    end
  end

  // ==========================================================
  // Pin drive.
  // Every pin is registered, so it follows a register write one cycle later without glitches.
  // The LCD role overrides the port direction, so software need not make the pin an output.
  logic                     master;
  logic                     phase;
  logic [3:0]               com_sel;
  logic [19:0]              seg_sel;
  logic [3:0]               com_data;
  lbpd_pin_t [3:0]          next_com_pin;
  lbpd_pin_t [19:0]         next_seg_pin;
  logic [1:0]               next_drive_current;

  assign master   = lcd_main_control[`LBPD_BIT_MASTER];
  assign phase    = lcd_main_control[`LBPD_BIT_PHASE];
  assign com_sel  = lcd_main_control[3:0];
  assign seg_sel  = {segment_enable_high[3:0], segment_enable_mid, segment_enable_low};
  assign com_data = {PORT_A_DATA[4], PORT_A_DATA[2], PORT_A_DATA[1], PORT_A_DATA[0]};

  always_comb begin
    next_drive_current = lcd_main_control[`LBPD_BIT_CUR_HI:`LBPD_BIT_CUR_LO];
    for (int i = 0; i < `LBPD_NCOM; i++) begin
      next_com_pin[i].lcd_mode = master && com_sel[i];
      next_com_pin[i].level    = LBPD_LV_VSS;
      if (master && com_sel[i]) begin
        next_com_pin[i].level = pick_level(1'b1, phase, com_data[i]);
      end
    end
    for (int j = 0; j < `LBPD_NSEG; j++) begin
      next_seg_pin[j].lcd_mode = master && seg_sel[j];
      next_seg_pin[j].level    = LBPD_LV_VSS;
      if (master && seg_sel[j]) begin
        next_seg_pin[j].level = pick_level(1'b0, phase, SEG_DATA[j]);
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      COM_PIN       <= '0;
      SEG_PIN       <= '0;
      DRIVE_CURRENT <= 2'h0;
    end else begin
      COM_PIN       <= next_com_pin;
      SEG_PIN       <= next_seg_pin;
      DRIVE_CURRENT <= next_drive_current;
    end
  end

  // ==========================================================
  // Checks.
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);

  logic [3:0]  com_mode_v;
  logic [19:0] seg_mode_v;
  logic        all_vss;
  always_comb begin
    all_vss = 1'b1;
    for (int k = 0; k < `LBPD_NCOM; k++) begin
      com_mode_v[k] = COM_PIN[k].lcd_mode;
      if (COM_PIN[k].level != LBPD_LV_VSS) begin
        all_vss = 1'b0;
      end
    end
    for (int m = 0; m < `LBPD_NSEG; m++) begin
      seg_mode_v[m] = SEG_PIN[m].lcd_mode;
      if (SEG_PIN[m].level != LBPD_LV_VSS) begin
        all_vss = 1'b0;
      end
    end
  end

  AST_MASTER_GATE: assert property (
    (com_mode_v != 4'h0 || seg_mode_v != 20'h00000) |-> $past(master))
    else $error("LCD pin role taken with master off.");
  AST_MASTER_OFF_VSS: assert property (
    !master ##1 1'b1 |-> all_vss && com_mode_v == 4'h0)
    else $error("Outputs not at ground with master off.");
  AST_COM_SELECT: assert property (
    com_mode_v == ($past(com_sel) & {4{$past(master)}}))
    else $error("Common role does not follow its enable.");
  AST_SEG_LOW_MID: assert property (
    seg_mode_v[15:0] == ($past(seg_sel[15:0]) & {16{$past(master)}}))
    else $error("Low or mid segment role does not follow its enable.");
  AST_SEG_MID_WRITE: assert property (
    wr_done && APB_REQ.paddr == `LBPD_OFS_SEG_MID && lcd_main_control[4]
    |-> ##2 seg_mode_v[15:8] == $past(APB_REQ.pwdata[7:0], 2) || $past(wr_done))
    else $error("Mid segment write not seen on pins.");
  AST_SEG_HIGH_READ: assert property (
    PREADY |-> PRDATA[31:8] == 24'h000000 &&
    ($past(APB_REQ.paddr) != `LBPD_OFS_SEG_HIGH || PRDATA[7:4] == 4'h0))
    else $error("High segment register upper bits not zero.");
  AST_COM_PHASE0: assert property (
    $past(master && com_sel[0] && !phase) |->
    COM_PIN[0].level == ($past(com_data[0]) ? LBPD_LV_VDD : LBPD_LV_THIRD))
    else $error("Common 0 level wrong in phase 0.");
  AST_SEG_PHASE1: assert property (
    $past(master && seg_sel[0] && phase) |->
    SEG_PIN[0].level == ($past(SEG_DATA[0]) ? LBPD_LV_VDD : LBPD_LV_THIRD))
    else $error("Segment 0 level wrong in phase 1.");
  AST_COM3_POLARITY: assert property (
    $past(master && com_sel[3] && phase && PORT_A_DATA[4]) |-> COM_PIN[3].level == LBPD_LV_VSS)
    else $error("Common 3 not driven from port A bit 4.");
  AST_CURRENT: assert property (
    DRIVE_CURRENT == $past(lcd_main_control[6:5]))
    else $error("Drive current does not follow its field.");
  AST_APB_ANSWER: assert property (
    APB_REQ.psel && !APB_REQ.penable |=> PREADY ##1 !PREADY)
    else $error("APB answer not one cycle after setup.");
  AST_SLVERR: assert property (
    PREADY |-> PSLVERR == !$past(addr_ok))
    else $error("Error response does not match the address map.");
  AST_PRDATA_IDLE: assert property (
    !PREADY |-> PRDATA == 32'h0000_0000 && !PSLVERR)
    else $error("Read data or error shown outside the access cycle.");
  AST_WRITE_UNMAPPED: assert property (
    wr_done && !addr_ok |=> $stable(lcd_main_control) && $stable(segment_enable_low) &&
    $stable(segment_enable_mid) && $stable(segment_enable_high))
    else $error("Write to an unmapped address changed a register.");

  // ==========================================================
  // Further pin checks.
  // Each check looks one cycle back, because the pins are registered copies of the decode.
  AST_SEG_HIGH_ROLE: assert property (
    seg_mode_v[19:16] == ($past(seg_sel[19:16]) & {4{$past(master)}}))
    else $error("High segment role does not follow its enable.");
  AST_COM_PHASE1: assert property (
    $past(master && com_sel[0] && phase) |->
    COM_PIN[0].level == ($past(com_data[0]) ? LBPD_LV_VSS : LBPD_LV_TWO_THIRD))
    else $error("Common 0 level wrong in phase 1.");
  AST_SEG_PHASE0: assert property (
    $past(master && seg_sel[0] && !phase) |->
    SEG_PIN[0].level == ($past(SEG_DATA[0]) ? LBPD_LV_VSS : LBPD_LV_TWO_THIRD))
    else $error("Segment 0 level wrong in phase 0.");
  AST_COM1_POLARITY: assert property (
    $past(master && com_sel[1] && !phase && PORT_A_DATA[1]) |->
    COM_PIN[1].level == LBPD_LV_VDD)
    else $error("Common 1 not driven from port A bit 1.");
  AST_COM2_POLARITY: assert property (
    $past(master && com_sel[2] && !phase && !PORT_A_DATA[2]) |->
    COM_PIN[2].level == LBPD_LV_THIRD)
    else $error("Common 2 not driven from port A bit 2.");

  AST_COM_DISABLED: assert property (
    !$past(com_sel[2]) |-> !COM_PIN[2].lcd_mode && COM_PIN[2].level == LBPD_LV_VSS)
    else $error("Disabled common 2 not released at ground.");
  AST_SEG_DISABLED: assert property (
    !$past(seg_sel[7]) |-> !SEG_PIN[7].lcd_mode && SEG_PIN[7].level == LBPD_LV_VSS)
    else $error("Disabled segment 7 not released at ground.");
  AST_SEG19_MODE: assert property (
    $past(master && seg_sel[19]) |-> SEG_PIN[19].lcd_mode)
    else $error("Enabled segment 19 not taken by the LCD driver.");
endmodule : lbpd_top

// ---- test/lbpd_panel.sv ----
// Passive panel model that reports the drive across the first pixel.
`timescale 1ns/100ps
module lbpd_panel (
  input  wire lbpd_pkg::lbpd_pin_t [3:0]  COM_PIN,
  input  wire lbpd_pkg::lbpd_pin_t [19:0] SEG_PIN,
  output logic [2:0]                      PIXEL_DRIVE
);
  import lbpd_pkg::*;
  // A pixel only sees the level difference between its common and segment lines.
  always_comb begin
    PIXEL_DRIVE = {1'b0, COM_PIN[0].level} - {1'b0, SEG_PIN[0].level};
  end
endmodule : lbpd_panel

// ---- test/testbench.sv ----
// Self-checking bench for the LCD bias pin driver control block.
`timescale 1ns/100ps
module testbench;
  import lbpd_pkg::*;
  logic                  ref_clk;
  logic                  nrst;
  lbpd_apb_req_t         req;
  logic                  pready;
  logic [31:0]           prdata;
  logic                  pslverr;
  logic [7:0]            port_a;
  logic [19:0]           seg_data;
  lbpd_pin_t [3:0]       com_pin;
  lbpd_pin_t [19:0]      seg_pin;
  logic [1:0]            drive_current;
  logic [2:0]            pixel;
  int                    mismatches = 0;
  int                    check_count = 0;
  int                    cycles = 0;
  lbpd_top u_lbpd_top (.REF_CLK(ref_clk), .NRST(nrst), .APB_REQ(req), .PREADY(pready),
    .PRDATA(prdata), .PSLVERR(pslverr), .PORT_A_DATA(port_a), .SEG_DATA(seg_data),
    .COM_PIN(com_pin), .SEG_PIN(seg_pin), .DRIVE_CURRENT(drive_current));
  lbpd_panel u_lbpd_panel (.COM_PIN(com_pin), .SEG_PIN(seg_pin), .PIXEL_DRIVE(pixel));
  // ==========================================================================
  // Clock, timeout and shared tasks.
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      final_report();
    end
  end
  task automatic final_report();
    if (mismatches == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge ref_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb
  function automatic logic [2:0] exp_pin(input logic on, input logic com, input logic p,
                                         input logic d);
    logic [7:0] t;
    t = com ? 8'h2D : 8'hD2;
    exp_pin = on ? {1'b1, t[2 * {p, d} +: 2]} : 3'h0;
  endfunction : exp_pin
  task automatic pins(input logic [3:0] cen, input logic [19:0] sen, input logic p);
    logic [3:0] cd;
    logic [2:0] ec;
    logic [2:0] es;
    cd = {port_a[4], port_a[2:0]};
    repeat (2) @(posedge ref_clk);
    for (int j = 0; j < 4; j++)
      chk({29'h0, com_pin[j]}, {29'h0, exp_pin(cen[j], 1'b1, p, cd[j])});
    for (int j = 0; j < 20; j++)
      chk({29'h0, seg_pin[j]}, {29'h0, exp_pin(sen[j], 1'b0, p, seg_data[j])});
    ec = exp_pin(cen[0], 1'b1, p, cd[0]);
    es = exp_pin(sen[0], 1'b0, p, seg_data[0]);
    chk({29'h0, pixel}, {29'h0, {1'b0, ec[1:0]} - {1'b0, es[1:0]}});
  endtask : pins
  // ==========================================================================
  // Scenarios.
  task automatic t_regs();
    logic [31:0] r;
    logic        e;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0, r, e);
      chk(r, 32'h0);
      apb(1'b1, 12'(4 * i), 32'hFFFFFFFF, r, e);
      apb(1'b0, 12'(4 * i), 32'h0, r, e);
      chk(r, (i == 3) ? 32'h0F : 32'hFF);
    end
    apb(1'b1, 12'h010, 32'hFF, r, e);
    chk({31'h0, e}, 32'h1);
    apb(1'b0, 12'h002, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
  endtask : t_regs
  task automatic t_master_off();
    logic [31:0] r;
    logic        e;
    apb(1'b1, 12'h000, 32'h6F, r, e);
    pins(4'h0, 20'h0, 1'b0);
    chk({30'h0, drive_current}, 32'h3);
  endtask : t_master_off
  task automatic t_levels();
    logic [31:0] r;
    logic        e;
    logic        p;
    logic        d;
    logic [1:0]  cur;
    for (int k = 0; k < 16; k++) begin
      {p, cur, d} = 4'(k);
      port_a <= 8'h05 ^ {8{d}};
      seg_data <= 20'h5A5A5 ^ {20{d}};
      apb(1'b1, 12'h000, {24'h0, p, cur, 5'h1F}, r, e);
      pins(4'hF, 20'hFFFFF, p);
      chk({30'h0, drive_current}, {30'h0, cur});
    end
  endtask : t_levels
  task automatic t_enables();
    logic [31:0] r;
    logic        e;
    apb(1'b1, 12'h000, 32'h15, r, e);
    apb(1'b1, 12'h004, 32'hA5, r, e);
    apb(1'b1, 12'h008, 32'h3C, r, e);
    apb(1'b1, 12'h00C, 32'h09, r, e);
    pins(4'h5, 20'h93CA5, 1'b0);
  endtask : t_enables
  initial begin
    ref_clk = 1'b0;
    nrst = 1'b0;
    req = '0;
    port_a = 8'h00;
    seg_data = 20'h0;
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    t_regs();
    t_master_off();
    t_levels();
    t_enables();
    final_report();
  end
endmodule : testbench
